// [inc/tac_pkg.sv]
// Purpose: constants shared by the tone activation control block
// Assumes: 250 MHz reference clock, 4 ns period
// Notes:   times are kept in ns; cycle counts are derived from them
`default_nettype none
package tac_pkg;

  // ==========================================================================
  // clock and timing
  localparam int unsigned CLK_PERIOD_NS = 4;     // reference clock period
  localparam int unsigned EXT_ON_NS     = 1000;  // external mode start delay
  localparam int unsigned EXT_OFF_NS    = 60000; // external mode stop delay
  localparam int unsigned ENV_ON_NS     = 6000;  // envelope mode start delay
  localparam int unsigned ENV_OFF_NS    = 15000; // envelope mode stop delay (least)
  localparam int unsigned TONE_HALF_NS  = 22727; // half period of 22 kHz tone
  // cycle counts, rounded down for these nominal times
  localparam int unsigned EXT_ON_CYC    = EXT_ON_NS / CLK_PERIOD_NS;
  localparam int unsigned EXT_OFF_CYC   = EXT_OFF_NS / CLK_PERIOD_NS;
  localparam int unsigned ENV_ON_CYC    = ENV_ON_NS / CLK_PERIOD_NS;
  localparam int unsigned ENV_OFF_CYC   = ENV_OFF_NS / CLK_PERIOD_NS;
  localparam int unsigned TONE_HALF_CYC = TONE_HALF_NS / CLK_PERIOD_NS;
  localparam int unsigned CNT_W         = 16;    // width of delay counters

  // ==========================================================================
  // section states
  typedef enum logic [2:0] {
    TAC_IDLE = 3'b001,   // tone off
    TAC_WAIT = 3'b010,   // start delay running
    TAC_ON   = 3'b100    // tone on supply output
  } tac_state_e;

  localparam int unsigned NUM_SECTIONS = 2;
  localparam logic        RST_TONE     = 1'b0;   // tone off after reset

endpackage
`default_nettype wire

// [inc/tac_sec_if.sv]
// Purpose: carries one section's controls and tone result
// Assumes: single clock domain
// Notes:   top keeps plain ports; this joins top and section module
`timescale 1ns/1ns
`default_nettype none
interface tac_sec_if;
  logic ext_sel;     // external waveform select
  logic tone_en;     // tone output enable
  logic key_sync;    // synchronised keying input
  logic tone;        // tone level onto supply output
  logic active;      // tone present on output

  modport top (output ext_sel, output tone_en, output key_sync,
               input tone, input active);
  modport sec (input ext_sel, input tone_en, input key_sync,
               output tone, output active);
endinterface
`default_nettype wire

// [rtl/tac_section.sv]
// Purpose: one independent tone section: mode select, delays, internal tone
// Assumes: keying input already synchronised
// Notes:   clock enable low freezes all state
`timescale 1ns/1ns
`default_nettype none
module tac_section (
  input  wire logic   ref_clk_in,   // reference clock
  input  wire logic   rst_in,       // synchronous reset, active high
  input  wire logic   clk_en_in,    // freeze when low
  input  wire logic   uvlo_in,      // whole circuit off
  tac_sec_if.sec      sec           // section controls and result
);

  // ==========================================================================
  // declarations
  tac_pkg::tac_state_e state_r, state_nxt;          // activation state
  logic [tac_pkg::CNT_W-1:0] dly_r, dly_nxt;        // delay counter
  logic [tac_pkg::CNT_W-1:0] gen_r;                 // internal tone divider
  logic                      gen_tone_r;            // internal 22 kHz square
  logic                      key_d_r;               // last keying level
  logic                      tone_r;                // registered output tone

  wire logic ext_mode  = sec.ext_sel & sec.tone_en;   // external waveform mode
  wire logic env_mode  = ~sec.ext_sel & sec.tone_en;  // envelope or continuous
  wire logic key_edge  = sec.key_sync ^ key_d_r;      // waveform activity
  // activity request: edges in ext mode, high level in envelope mode
  wire logic request   = ext_mode ? key_edge : (env_mode & sec.key_sync);
  wire logic [tac_pkg::CNT_W-1:0] on_cyc  = ext_mode ?
      tac_pkg::CNT_W'(tac_pkg::EXT_ON_CYC)  : tac_pkg::CNT_W'(tac_pkg::ENV_ON_CYC);
  wire logic [tac_pkg::CNT_W-1:0] off_cyc = ext_mode ?
      tac_pkg::CNT_W'(tac_pkg::EXT_OFF_CYC) : tac_pkg::CNT_W'(tac_pkg::ENV_OFF_CYC);
  wire logic gate_off  = ~sec.tone_en | uvlo_in;       // hard stop
  // ext mode follows keying waveform, else internal generator
  wire logic tone_src  = ext_mode ? sec.key_sync : gen_tone_r;

  // ==========================================================================
  // next state: start delay, then on, then stop after quiet time
  always_comb begin
    state_nxt = state_r;
    dly_nxt   = dly_r;
    case (state_r)
      tac_pkg::TAC_IDLE: begin
        if (request) begin                                   // activity seen
          state_nxt = tac_pkg::TAC_WAIT;
          dly_nxt   = on_cyc;
        end
      end
      tac_pkg::TAC_WAIT: begin
        if (!request && !ext_mode) begin                     // envelope dropped early
          state_nxt = tac_pkg::TAC_IDLE;
        end else if (dly_r <= tac_pkg::CNT_W'(1)) begin       // start delay
          state_nxt = tac_pkg::TAC_ON;
          dly_nxt   = off_cyc;
        end else begin
          dly_nxt   = dly_r - tac_pkg::CNT_W'(1);
        end
      end
      tac_pkg::TAC_ON: begin
        if (request) begin                                   // restart quiet timer
          dly_nxt = off_cyc;
        end else if (dly_r <= tac_pkg::CNT_W'(1)) begin       // stop delay
          state_nxt = tac_pkg::TAC_IDLE;
        end else begin
          dly_nxt   = dly_r - tac_pkg::CNT_W'(1);
        end
      end
      default: begin
        state_nxt = tac_pkg::TAC_IDLE;
      end
    endcase
    if (gate_off) begin
      state_nxt = tac_pkg::TAC_IDLE;
      dly_nxt   = '0;
    end
  end

  // ==========================================================================
  // state registers
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      state_r <= tac_pkg::TAC_IDLE;
      dly_r   <= '0;
      key_d_r <= 1'b0;
    end else if (clk_en_in) begin
      state_r <= state_nxt;
      dly_r   <= dly_nxt;
      key_d_r <= sec.key_sync;
    end
  end

  // ==========================================================================
  // internal 22 kHz generator, free running whenever envelope mode is enabled and lockout is clear, in every state
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      gen_r      <= '0;
      gen_tone_r <= 1'b0;
    end else if (clk_en_in) begin
      if (gate_off || ext_mode) begin                        // idle, keep phase fixed
        gen_r      <= '0;
        gen_tone_r <= 1'b0;
      end else if (gen_r >= tac_pkg::CNT_W'(tac_pkg::TONE_HALF_CYC - 1)) begin
        gen_r      <= '0;
        gen_tone_r <= ~gen_tone_r;
      end else begin
        gen_r      <= gen_r + tac_pkg::CNT_W'(1);
      end
    end
  end

  // ==========================================================================
  // output tone register; continuous tone falls out of envelope mode
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      tone_r <= tac_pkg::RST_TONE;
    end else if (clk_en_in) begin
      tone_r <= (state_r == tac_pkg::TAC_ON) & ~gate_off & tone_src;
    end
  end

  assign sec.tone   = tone_r;
  assign sec.active = (state_r == tac_pkg::TAC_ON);

endmodule
`default_nettype wire

// [rtl/tac_top.sv]
// Purpose: two section tone activation control with undervoltage lockout
// Assumes: host keeps low power select at zero while toning
// Notes:   keying inputs and supply sense are asynchronous pins
`timescale 1ns/1ns
`default_nettype none

module tac_top (
  input  wire logic       ref_clk_in,                      // reference clock
  input  wire logic       rst_in,                          // sync reset, high
  input  wire logic       clk_en_in,                       // freeze when low
  input  wire logic       uvlo_in,                         // supply below lockout, pin
  input  wire logic [1:0] external_waveform_select_in,     // per section mode bit
  input  wire logic [1:0] tone_output_enable_in,           // per section enable bit
  input  wire logic [1:0] low_power_select_in,             // per section low power bit
  input  wire logic [1:0] tone_keying_input_in,            // per section keying pins
  output logic      [1:0] supply_output_tone_out,          // tone onto supply output
  output logic      [1:0] tone_active_out,                 // tone gate state
  output logic      [1:0] low_power_eff_out                // low power actually applied
);

  // ==========================================================================
  // pin synchronisers: first stage read only by second
  logic [1:0] key_s1_r, key_s2_r;   // keying synchroniser
  logic       uv_s1_r, uv_s2_r;     // lockout synchroniser
  logic [1:0] lp_r;                 // low power output register

  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      key_s1_r <= 2'h0;
      key_s2_r <= 2'h0;
      uv_s1_r  <= 1'b1;             // assume lockout until supply seen good
      uv_s2_r  <= 1'b1;
    end else if (clk_en_in) begin
      key_s1_r <= tone_keying_input_in;
      key_s2_r <= key_s1_r;
      uv_s1_r  <= uvlo_in;
      uv_s2_r  <= uv_s1_r;
    end
  end

  // ==========================================================================
  // two fully independent sections
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_sec
      tac_sec_if sif ();
      assign sif.ext_sel  = external_waveform_select_in[g];
      assign sif.tone_en  = tone_output_enable_in[g];
      assign sif.key_sync = key_s2_r[g];
      tac_section u_sec (
        .ref_clk_in (ref_clk_in),
        .rst_in     (rst_in),
        .clk_en_in  (clk_en_in),
        .uvlo_in    (uv_s2_r),     // shared lockout
        .sec        (sif.sec)
      );
      assign supply_output_tone_out[g] = sif.tone;
      assign tone_active_out[g]        = sif.active;
    end
  endgenerate

  // ==========================================================================
  // low power honoured only while no tone; host should not rely on it
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      lp_r <= 2'h0;
    end else if (clk_en_in) begin
      lp_r <= low_power_select_in & ~tone_active_out;
    end
  end
  assign low_power_eff_out = lp_r;

endmodule
`default_nettype wire

// [dv/tac_host_model.sv]
// Purpose: host side model that drives the keying pins
// Assumes: the bench sets the mode and enable bits first
// Notes:   pins change on the falling edge only
`timescale 1ns/1ns
`default_nettype none
module tac_host_model (
  input  wire logic       ref_clk_in,  // reference clock
  output var  logic [1:0] key_out      // keying pin per section
);
  initial key_out = 2'b00;
  // ==========================================================
  // envelope: level high for n cycles
  task automatic pulse(input int s, input int n);
    @(negedge ref_clk_in) key_out[s] = 1'b1;
    repeat (n) @(negedge ref_clk_in);
    key_out[s] = 1'b0;
  endtask
  // 22 kHz square wave, h half periods
  task automatic wave(input int s, input int h);
    repeat (h) begin
      @(negedge ref_clk_in) key_out[s] = ~key_out[s];
      repeat (tac_pkg::TONE_HALF_CYC - 1) @(negedge ref_clk_in);
    end
  endtask
endmodule
`default_nettype wire

// [dv/tac_top_properties.sv]
// Purpose: port timing checks for tac_top
// Assumes: one clock; delays timed on section 0 only
// Notes:   run_r counts cycles since the last keying edge
`timescale 1ns/1ns
`default_nettype none
module tac_top_properties (
  input wire logic       ref_clk_in,
  input wire logic       rst_in,
  input wire logic       clk_en_in,
  input wire logic       uvlo_in,
  input wire logic [1:0] external_waveform_select_in,
  input wire logic [1:0] tone_output_enable_in,
  input wire logic [1:0] low_power_select_in,
  input wire logic [1:0] tone_keying_input_in,
  input wire logic [1:0] supply_output_tone_out,
  input wire logic [1:0] tone_active_out,
  input wire logic [1:0] low_power_eff_out
);
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (rst_in);
  logic [15:0] run_r;  // cycles since keying edge, saturates
  logic        key_r;  // keying level one edge ago
  wire         ext0 = external_waveform_select_in[0];
  wire         en0  = tone_output_enable_in[0];
  wire         k0   = tone_keying_input_in[0];
  // ==========================================================
  // edge-to-edge counter, saturating so a long idle never wraps
  // a keying edge must restart it even from the saturated value
  always_ff @(posedge ref_clk_in) begin
    key_r <= k0;
    if (rst_in) begin
      run_r <= 16'hffff;
    end else if (key_r != k0) begin
      run_r <= 16'h0000;
    end else if (run_r != 16'hffff) begin
      run_r <= run_r + 16'h0001;
    end
  end
  AST_EN_OFF: assert property (clk_en_in |=>
    (tone_active_out & ~$past(tone_output_enable_in)) == 2'b00) else $error("tone without enable");
  AST_UVLO: assert property ((clk_en_in && uvlo_in) [*3] |=>
    tone_active_out == 2'b00) else $error("tone during lockout");
  AST_QUIET: assert property (!tone_active_out[0] [*2] |->
    !supply_output_tone_out[0]) else $error("supply tone while idle");
  AST_ENV_ON: assert property ($rose(tone_active_out[0]) && !ext0 |->
    k0 && run_r inside {[1490:1520]}) else $error("envelope start delay");
  AST_ENV_OFF: assert property ($fell(tone_active_out[0]) && !ext0 && en0 && !uvlo_in |->
    !k0 && run_r inside {[3740:3770]}) else $error("envelope stop delay");
  AST_EXT_ON: assert property ($rose(tone_active_out[0]) && ext0 |->
    run_r inside {[240:270]}) else $error("waveform start delay");
  AST_EXT_OFF: assert property ($fell(tone_active_out[0]) && ext0 && en0 && !uvlo_in |->
    run_r inside {[14990:15020]}) else $error("waveform stop delay");
  AST_FOLLOW: assert property ((ext0 && en0 && tone_active_out[0] && $stable(k0)) [*6] |->
    supply_output_tone_out[0] == k0) else $error("tone not following keying");
endmodule
`default_nettype wire

// [dv/tac_top_tb_top.sv]
// Purpose: self-checking bench for tac_top
// Assumes: 250 MHz clock, synchronous reset
// Notes:   expected levels are worked out from the delays
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, e, g) begin n_tests++; if ((g) !== (e)) begin fails++; \
  $display("[FAIL] %s exp %b got %b", n, e, g); end end
module tac_top_tb_top;
  logic        ref_clk_in = 1'b0;
  logic        rst_in = 1'b1;
  logic        uvlo_in = 1'b1;
  logic [1:0]  ext_r = 2'b00;
  logic [1:0]  en_r = 2'b00;
  logic [1:0]  lp_r = 2'b00;
  logic [1:0]  rnd_r = 2'b00;  // bench keying in the host's place
  logic [1:0]  hkey;
  logic [1:0]  act;
  logic        ce_r = 1'b1;   // clock enable, dropped once to test freezing
  logic [1:0]  tone_o;        // supply output tone per section
  logic [1:0]  lp_o;          // low power actually applied
  int          hi = 0;        // negedges the tone stayed high
  logic [31:0] lfsr_r = 32'hee6f132f;
  int          fails = 0;
  int          n_tests = 0;
  int          cyc = 0;
  tac_host_model HOST (.ref_clk_in(ref_clk_in), .key_out(hkey));
  tac_top DUT (.ref_clk_in(ref_clk_in), .rst_in(rst_in), .clk_en_in(ce_r), .uvlo_in(uvlo_in),
    .external_waveform_select_in(ext_r), .tone_output_enable_in(en_r),
    .low_power_select_in(lp_r), .tone_keying_input_in(hkey ^ rnd_r),
    .supply_output_tone_out(tone_o), .tone_active_out(act), .low_power_eff_out(lp_o));
  initial forever #2 ref_clk_in = ~ref_clk_in;
  always @(posedge ref_clk_in) cyc++;
  function automatic logic [31:0] lfsr(logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  task automatic stop_test;
    $display("checks %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // one keying burst; len is the time of its last edge
  task automatic run_case(input int s, input int ext, input int len);
    int t0;
    int on;
    int off;
    int pts [4];
    logic ea;  // expected gate state at this point
    logic et;  // expected tone level at this point
    @(negedge ref_clk_in);
    ext_r = ext ? 2'b11 : 2'b00;
    en_r = 2'b11;
    on = ext ? 253 : 1503;
    off = len + (ext ? 15002 : 3753);
    pts = '{on - 40, on + 40, off - 40, off + 40};
    fork
      if (ext) HOST.wave(s, len / tac_pkg::TONE_HALF_CYC + 1); else HOST.pulse(s, len);
    join_none
    t0 = cyc + 1;
    foreach (pts[i]) begin
      repeat (t0 + pts[i] - cyc) @(posedge ref_clk_in);
      #1;
      ea = (ext != 0 || len > on) && pts[i] > on && pts[i] < off;
      // waveform mode copies the keying level, envelope mode the internal half periods
      et = ea && (ext != 0 ? pts[i] < len : (pts[i] / tac_pkg::TONE_HALF_CYC) % 2 == 1);
      `CHK("active", ea, act[s])
      `CHK("tone", et, tone_o[s])
      `CHK("other", 1'b0, act[1 - s])
    end
    $display("case %0d %0d %0d done", s, ext, len);
  endtask
  initial begin
    repeat (4) @(posedge ref_clk_in);
    @(negedge ref_clk_in) rst_in = 1'b0;
    uvlo_in = 1'b0;
    run_case(0, 0, 3000);  // envelope
    run_case(0, 0, 1000);  // envelope dropped during start delay
    run_case(0, 1, tac_pkg::TONE_HALF_CYC);  // external waveform
    run_case(1, 0, 2000);
    @(negedge ref_clk_in) en_r = 2'b00;
    repeat (2000) begin
      @(negedge ref_clk_in);
      `CHK("low power", lp_r, lp_o)
      lfsr_r = lfsr(lfsr_r);
      {lp_r, ext_r, rnd_r} = lfsr_r[5:0];
      `CHK("idle", 2'b00, act)
    end
    $display("idle done");
    {lp_r, ext_r, rnd_r} = 6'h00;  // low power clear before toning
    en_r = 2'b11;
    fork
      HOST.pulse(0, 2000);
      HOST.pulse(1, 2000);
    join_none
    repeat (1700) @(negedge ref_clk_in);
    `CHK("both on", 2'b11, act)
    uvlo_in = 1'b1;
    repeat (4) @(negedge ref_clk_in);
    `CHK("lockout", 2'b00, act)
    repeat (400) @(negedge ref_clk_in);
    uvlo_in = 1'b0;
    $display("lockout done");
    {rnd_r, en_r} = 4'h8;
    repeat (10) @(negedge ref_clk_in);
    en_r = 2'b10;
    repeat (700) @(negedge ref_clk_in);
    ce_r = 1'b0;  // frozen: the start delay must not advance
    repeat (100) @(negedge ref_clk_in);
    ce_r = 1'b1;
    repeat (760) @(negedge ref_clk_in);
    `CHK("cont early", 1'b0, act[1])
    repeat (80) @(negedge ref_clk_in);
    `CHK("cont on", 1'b1, act[1])
    // internal tone: one high half period measured on the supply output
    repeat (6000) if (!tone_o[1]) @(negedge ref_clk_in);
    while (tone_o[1] && hi < 6000) begin
      @(negedge ref_clk_in);
      hi++;
    end
    `CHK("tone half", tac_pkg::TONE_HALF_CYC, hi)
    en_r = 2'b00;
    repeat (2) @(negedge ref_clk_in);
    `CHK("cont off", 1'b0, act[1])
    $display("continuous done");
    stop_test();
  end
  initial begin
    repeat (90000) @(posedge ref_clk_in);
    fails++;
    stop_test();
  end
endmodule
bind tac_top tac_top_properties PROPS (.ref_clk_in(ref_clk_in), .rst_in(rst_in),
  .clk_en_in(clk_en_in), .uvlo_in(uvlo_in),
  .external_waveform_select_in(external_waveform_select_in),
  .tone_output_enable_in(tone_output_enable_in), .low_power_select_in(low_power_select_in),
  .tone_keying_input_in(tone_keying_input_in), .supply_output_tone_out(supply_output_tone_out),
  .tone_active_out(tone_active_out), .low_power_eff_out(low_power_eff_out));
`default_nettype wire
